// File: logic/eeprom_loader_pkg.sv
// constants of the power-up serial eeprom loader
// assumes one device clock and a synchronous active-low reset
package eeprom_loader_pkg;
   // ************************************************
   // clock and serial bus timing
   // ************************************************
   localparam int CLK_PERIOD_NS  = 4;
   // fast bus clock keeps a load near 4330 cycles; slow parts need a larger half period
   localparam int SCL_HALF_NS    = 24;
   localparam int SCL_HALF_CYC   = SCL_HALF_NS / CLK_PERIOD_NS;
   localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;
   // ************************************************
   // eeprom map
   // ************************************************
   localparam logic [7:0] EE_LAST_BYTE  = 8'h16;
   localparam logic [7:0] EE_LATGNT     = 8'h00;
   localparam logic [7:0] EE_VENDOR_LO  = 8'h01;
   localparam logic [7:0] EE_VENDOR_HI  = 8'h02;
   localparam logic [7:0] EE_SUBSYS_LO  = 8'h03;
   localparam logic [7:0] EE_SUBSYS_HI  = 8'h04;
   localparam logic [7:0] EE_ENHANCE    = 8'h05;
   localparam logic [7:0] EE_UID_ROM    = 8'h06;
   localparam logic [7:0] EE_UID_HI0    = 8'h07;
   localparam logic [7:0] EE_UID_HI3    = 8'h0A;
   localparam logic [7:0] EE_UID_LO0    = 8'h0B;
   localparam logic [7:0] EE_UID_LO3    = 8'h0E;
   localparam logic [7:0] EE_LINK_HI    = 8'h10;
   localparam logic [7:0] EE_MISC_LO    = 8'h11;
   localparam logic [7:0] EE_MISC_HI    = 8'h12;
   localparam logic [7:0] EE_PHY_CTRL   = 8'h16;
   // ************************************************
   // target register offsets and fields
   // ************************************************
   localparam logic [7:0] LINK_ENH_OFFSET = 8'hF4;
   localparam int LE_UNFAIR_BIT = 7;
   localparam int LE_ACCEL_BIT  = 1;
   localparam int EE_PHYPROG_BIT = 6;
   localparam int MISC_B15 = 7;
   localparam int MISC_B4  = 4;
   localparam logic [31:0] LINK_ENH_RESET = 32'h0000_0000;
   localparam logic [31:0] LINK_ENH_RMASK = 32'h0000_F082;
   localparam logic [15:0] ID16_RESET    = 16'h0000;
   localparam logic [31:0] UID_RESET     = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_START = 4'b0001,
      ST_DEVW  = 4'b0010,
      ST_WADDR = 4'b0011,
      ST_RSTRT = 4'b0100,
      ST_DEVR  = 4'b0101,
      ST_READ  = 4'b0110,
      ST_STOP  = 4'b0111,
      ST_DONE  = 4'b1000
   } load_state_e;
   typedef enum logic [2:0] {
      BC_NONE  = 3'b000,
      BC_START = 3'b001,
      BC_STOP  = 3'b010,
      BC_WRITE = 3'b011,
      BC_READ  = 3'b100
   } bit_cmd_e;
endpackage

// File: logic/serial_bit_engine.sv
// two-wire byte engine: start, stop, byte write with ack sample, byte read with ack drive
// assumes open-drain pins with pull-ups outside; one command at a time
`timescale 1ns/1ps
module serial_bit_engine (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  cmd,
   input  wire logic        cmdValid,
   input  wire logic [7:0]  txByte,
   input  wire logic        lastRead,
   output logic             busy,
   output logic             cmdDone,
   output logic [7:0]       rxByte,
   output logic             ackSeen,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sclOut,
   output logic             sclOe,
   output logic             sdaOut,
   output logic             sdaOe
);
   // ************************************************
   // state
   // ************************************************
   logic [2:0]  cmd_reg, cmd_next;
   logic [11:0] div_reg, div_next;
   logic [1:0]  ph_reg, ph_next;
   logic [3:0]  bit_reg, bit_next;
   logic [8:0]  sh_reg, sh_next;
   logic        sclLow_reg, sclLow_next, sdaLow_reg, sdaLow_next;
   logic        done_reg, done_next, ack_reg, ack_next;
   logic [1:0]  sdaSync_reg, sclSync_reg;
   logic        tick;

   // pins pass two flops before use
   always_ff @(posedge clk) begin
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclSync_reg <= {sclSync_reg[0], sclIn};
   end

   assign tick = (div_reg == 12'(eeprom_loader_pkg::SCL_HALF_CYC - 1));

   always_comb begin
      cmd_next = cmd_reg;
      div_next = (cmd_reg == 3'(eeprom_loader_pkg::BC_NONE) || tick) ? 12'h000 : div_reg + 12'h001;
      ph_next = ph_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      sclLow_next = sclLow_reg;
      sdaLow_next = sdaLow_reg;
      done_next = 1'b0;
      ack_next = ack_reg;
      if (cmd_reg == 3'(eeprom_loader_pkg::BC_NONE)) begin
         if (cmdValid) begin
            cmd_next = cmd;
            ph_next = 2'd0;
            bit_next = 4'd0;
            // read shifts ones so sda is released, last bit is our ack
            sh_next = (cmd == 3'(eeprom_loader_pkg::BC_READ)) ? {8'hFF, lastRead}
                                                             : {txByte, 1'b1};
         end
      end else if (tick) begin
         ph_next = ph_reg + 2'd1;
         case (cmd_reg)
            eeprom_loader_pkg::BC_START: begin
               // sda falls while scl is high
               if (ph_reg == 2'd0) begin
                  sclLow_next = 1'b0;
                  sdaLow_next = 1'b0;
               end else if (ph_reg == 2'd1) begin
                  sdaLow_next = 1'b1;
               end else begin
                  sclLow_next = 1'b1;
                  cmd_next = 3'(eeprom_loader_pkg::BC_NONE);
                  done_next = 1'b1;
               end
            end
            eeprom_loader_pkg::BC_STOP: begin
               if (ph_reg == 2'd0) begin
                  sdaLow_next = 1'b1;
               end else if (ph_reg == 2'd1) begin
                  sclLow_next = 1'b0;
               end else begin
                  sdaLow_next = 1'b0;
                  cmd_next = 3'(eeprom_loader_pkg::BC_NONE);
                  done_next = 1'b1;
               end
            end
            default: begin
               // phase 0 set data, 1 raise scl, 2 sample and drop scl
               if (ph_reg == 2'd0) begin
                  sdaLow_next = ~sh_reg[8];
               end else if (ph_reg == 2'd1) begin
                  sclLow_next = 1'b0;
               end else begin
                  sclLow_next = 1'b1;
                  ph_next = 2'd0;
                  sh_next = {sh_reg[7:0], sdaSync_reg[1]};
                  bit_next = bit_reg + 4'd1;
                  if (bit_reg == 4'd8) begin
                     cmd_next = 3'(eeprom_loader_pkg::BC_NONE);
                     done_next = 1'b1;
                     // sda kept until next phase 0, never moving as scl falls
                     ack_next = ~sdaSync_reg[1];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_reg <= 3'(eeprom_loader_pkg::BC_NONE);
         div_reg <= 12'h000;
         ph_reg <= 2'd0;
         bit_reg <= 4'd0;
         sh_reg <= 9'h1FF;
         sclLow_reg <= 1'b0;
         sdaLow_reg <= 1'b0;
         done_reg <= 1'b0;
         ack_reg <= 1'b0;
      end else begin
         cmd_reg <= cmd_next;
         div_reg <= div_next;
         ph_reg <= ph_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         sclLow_reg <= sclLow_next;
         sdaLow_reg <= sdaLow_next;
         done_reg <= done_next;
         ack_reg <= ack_next;
      end
   end

   assign busy    = (cmd_reg != 3'(eeprom_loader_pkg::BC_NONE));
   assign cmdDone = done_reg;
   assign ackSeen = ack_reg;
   assign rxByte  = sh_reg[8:1];
   assign sclOut  = 1'b0;
   assign sclOe   = sclLow_reg;
   assign sdaOut  = 1'b0;
   assign sdaOe   = sdaLow_reg;
endmodule // serial_bit_engine

// File: logic/config_target_regs.sv
// target register fields filled by the loader
// assumes one byte write strobe per eeprom byte from the sequencer
`timescale 1ns/1ps
module config_target_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        byteWe,
   input  wire logic [7:0]  byteAddr,
   input  wire logic [7:0]  byteData,
   output logic [15:0]      latGnt,
   output logic [15:0]      vendorId,
   output logic [15:0]      subsysId,
   output logic [7:0]       uidRom,
   output logic [31:0]      uidHigh,
   output logic [31:0]      uidLow,
   output logic [31:0]      linkEnh,
   output logic             phyProgrammingAllow,
   output logic [1:0]       miscBits,
   output logic [7:0]       phyCtrl
);
   // ************************************************
   // one strobe-keyed register per field
   // ************************************************
   logic [15:0] latGnt_reg, vendor_reg, subsys_reg;
   logic [7:0]  uidRom_reg, phy_reg;
   logic [31:0] uidHi_reg, uidLo_reg;
   logic [3:0]  leHi_reg;
   logic        unfair_reg, accel_reg, phyProg_reg;
   logic [1:0]  misc_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latGnt_reg <= eeprom_loader_pkg::ID16_RESET;
         vendor_reg <= eeprom_loader_pkg::ID16_RESET;
         subsys_reg <= eeprom_loader_pkg::ID16_RESET;
         uidRom_reg <= eeprom_loader_pkg::BYTE_RESET;
         phy_reg <= eeprom_loader_pkg::BYTE_RESET;
         uidHi_reg <= eeprom_loader_pkg::UID_RESET;
         uidLo_reg <= eeprom_loader_pkg::UID_RESET;
         leHi_reg <= 4'h0;
         unfair_reg <= 1'b0;
         accel_reg <= 1'b0;
         phyProg_reg <= 1'b0;
         misc_reg <= 2'b00;
      end else if (byteWe) begin
         if (byteAddr == eeprom_loader_pkg::EE_LATGNT) begin
            latGnt_reg <= {8'h00, byteData};
         end else if (byteAddr == eeprom_loader_pkg::EE_VENDOR_LO) begin
            vendor_reg[7:0] <= byteData;
         end else if (byteAddr == eeprom_loader_pkg::EE_VENDOR_HI) begin
            vendor_reg[15:8] <= byteData;
         end else if (byteAddr == eeprom_loader_pkg::EE_SUBSYS_LO) begin
            subsys_reg[7:0] <= byteData;
         end else if (byteAddr == eeprom_loader_pkg::EE_SUBSYS_HI) begin
            subsys_reg[15:8] <= byteData;
         end else if (byteAddr == eeprom_loader_pkg::EE_ENHANCE) begin
            unfair_reg <= byteData[eeprom_loader_pkg::LE_UNFAIR_BIT];
            accel_reg <= byteData[eeprom_loader_pkg::LE_ACCEL_BIT];
            phyProg_reg <= byteData[eeprom_loader_pkg::EE_PHYPROG_BIT];
         end else if (byteAddr == eeprom_loader_pkg::EE_UID_ROM) begin
            uidRom_reg <= byteData;
         end else if (byteAddr >= eeprom_loader_pkg::EE_UID_HI0 &&
                      byteAddr <= eeprom_loader_pkg::EE_UID_HI3) begin
            uidHi_reg <= {byteData, uidHi_reg[31:8]};
         end else if (byteAddr >= eeprom_loader_pkg::EE_UID_LO0 &&
                      byteAddr <= eeprom_loader_pkg::EE_UID_LO3) begin
            uidLo_reg <= {byteData, uidLo_reg[31:8]};
         end else if (byteAddr == eeprom_loader_pkg::EE_LINK_HI) begin
            leHi_reg <= byteData[7:4];
         end else if (byteAddr == eeprom_loader_pkg::EE_MISC_LO) begin
            misc_reg[0] <= byteData[eeprom_loader_pkg::MISC_B4];
         end else if (byteAddr == eeprom_loader_pkg::EE_MISC_HI) begin
            misc_reg[1] <= byteData[eeprom_loader_pkg::MISC_B15];
         end else if (byteAddr == eeprom_loader_pkg::EE_PHY_CTRL) begin
            phy_reg <= byteData;
         end
      end
   end

   assign latGnt = latGnt_reg;
   assign vendorId = vendor_reg;
   assign subsysId = subsys_reg;
   assign uidRom = uidRom_reg;
   assign uidHigh = uidHi_reg;
   assign uidLow = uidLo_reg;
   // reserved bits read zero, bit 6 unassigned here
   assign linkEnh = {16'h0000, leHi_reg, 4'h0, unfair_reg, 5'b00000, accel_reg, 1'b0};
   assign phyProgrammingAllow = phyProg_reg;
   assign miscBits = misc_reg;
   assign phyCtrl = phy_reg;
endmodule // config_target_regs

// File: logic/serial_eeprom_config_loader.sv
// top of the power-up eeprom loader: sequencer, retry flag and link enables
// assumes open-drain serial pins pulled up on the board and a host slave unit
// that honours loadRetry
//
// Summary of operation
// - after reset the eeprom is read and registers loaded without software help
// - eeprom reached only over the two-wire bus, this block always master
// - host slave accesses are retried while the load runs
// - byte 00h to latency/grant, 01h vendor id, 03h subsystem id
// - byte 06h to id rom, 07h-0Ah id high, 0Bh-0Eh id low
// - byte 05h bits 7,1 to link enhancement, bit 6 allows phy programming
// - byte 10h link bits 15-12, 11h-12h misc bits, 16h phy control
// - link enhancement bit 7 lets the link answer priority requests
// - link enhancement bit 1 tells the phy acceleration is supported
// - link enhancement bits 6-2 and 0 read zero
`timescale 1ns/1ps
module serial_eeprom_config_loader (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sclOut,
   output logic             sclOe,
   output logic             sdaOut,
   output logic             sdaOe,
   output logic             loadRetry,
   output logic             loadFailed,
   input  wire logic [7:0]  regOffset,
   output logic [31:0]      regReadData,
   output logic [15:0]      latGnt,
   output logic [15:0]      vendorId,
   output logic [15:0]      subsysId,
   output logic [7:0]       uidRom,
   output logic [31:0]      uidHigh,
   output logic [31:0]      uidLow,
   output logic             phyProgrammingAllow,
   output logic [1:0]       miscBits,
   output logic [7:0]       phyCtrl,
   output logic             priorityArbRespond,
   output logic             accelSupportNotify
);
   // ************************************************
   // sequencer state
   // ************************************************
   eeprom_loader_pkg::load_state_e state_reg, state_next;
   logic [7:0]  addr_reg, addr_next;
   logic        issued_reg, issued_next;
   logic        fail_reg, fail_next;
   logic [2:0]  cmd;
   logic        cmdValid, busy, cmdDone, ackSeen, lastRead, byteWe;
   logic [7:0]  txByte, rxByte;
   logic [31:0] linkEnh;

   // issue one engine command per state (one per byte in ST_READ), advance on its done pulse
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      issued_next = issued_reg;
      fail_next = fail_reg;
      cmd = 3'(eeprom_loader_pkg::BC_NONE);
      txByte = 8'h00;
      byteWe = 1'b0;
      cmdValid = 1'b0;
      case (state_reg)
         eeprom_loader_pkg::ST_IDLE: begin
            state_next = eeprom_loader_pkg::ST_START;
         end
         eeprom_loader_pkg::ST_START, eeprom_loader_pkg::ST_RSTRT: begin
            cmd = 3'(eeprom_loader_pkg::BC_START);
         end
         eeprom_loader_pkg::ST_DEVW: begin
            cmd = 3'(eeprom_loader_pkg::BC_WRITE);
            txByte = {eeprom_loader_pkg::EEPROM_DEV_ADDR, 1'b0};
         end
         eeprom_loader_pkg::ST_WADDR: begin
            cmd = 3'(eeprom_loader_pkg::BC_WRITE);
            txByte = 8'h00;
         end
         eeprom_loader_pkg::ST_DEVR: begin
            cmd = 3'(eeprom_loader_pkg::BC_WRITE);
            txByte = {eeprom_loader_pkg::EEPROM_DEV_ADDR, 1'b1};
         end
         eeprom_loader_pkg::ST_READ: begin
            cmd = 3'(eeprom_loader_pkg::BC_READ);
         end
         eeprom_loader_pkg::ST_STOP: begin
            cmd = 3'(eeprom_loader_pkg::BC_STOP);
         end
         default: begin
            cmd = 3'(eeprom_loader_pkg::BC_NONE);
         end
      endcase
      if (cmd != 3'(eeprom_loader_pkg::BC_NONE) && !issued_reg && !busy) begin
         cmdValid = 1'b1;
         issued_next = 1'b1;
      end
      if (cmdDone) begin
         issued_next = 1'b0;
         case (state_reg)
            eeprom_loader_pkg::ST_START: state_next = eeprom_loader_pkg::ST_DEVW;
            eeprom_loader_pkg::ST_DEVW: begin
               if (ackSeen) begin
                  state_next = eeprom_loader_pkg::ST_WADDR;
               end else begin
                  fail_next = 1'b1;
                  state_next = eeprom_loader_pkg::ST_STOP;
               end
            end
            eeprom_loader_pkg::ST_WADDR: state_next = eeprom_loader_pkg::ST_RSTRT;
            eeprom_loader_pkg::ST_RSTRT: state_next = eeprom_loader_pkg::ST_DEVR;
            eeprom_loader_pkg::ST_DEVR: begin
               if (ackSeen) begin
                  state_next = eeprom_loader_pkg::ST_READ;
               end else begin
                  fail_next = 1'b1;
                  state_next = eeprom_loader_pkg::ST_STOP;
               end
            end
            eeprom_loader_pkg::ST_READ: begin
               // sequential read, eeprom contents trusted as programmed
               byteWe = 1'b1;
               addr_next = addr_reg + 8'h01;
               if (addr_reg == eeprom_loader_pkg::EE_LAST_BYTE) begin
                  state_next = eeprom_loader_pkg::ST_STOP;
               end
            end
            eeprom_loader_pkg::ST_STOP: state_next = eeprom_loader_pkg::ST_DONE;
            default: state_next = state_reg;
         endcase
      end
   end

   assign lastRead = (addr_reg == eeprom_loader_pkg::EE_LAST_BYTE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= eeprom_loader_pkg::ST_IDLE;
         addr_reg <= 8'h00;
         issued_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         issued_reg <= issued_next;
         fail_reg <= fail_next;
      end
   end

   // ************************************************
   // host retry and failure status
   // ************************************************
   assign loadRetry = (state_reg != eeprom_loader_pkg::ST_DONE);
   assign loadFailed = fail_reg;

   // ************************************************
   // submodules
   // ************************************************
   serial_bit_engine engine (
      .clk      (clk),
      .rst_n    (rst_n),
      .cmd      (cmd),
      .cmdValid (cmdValid),
      .txByte   (txByte),
      .lastRead (lastRead),
      .busy     (busy),
      .cmdDone  (cmdDone),
      .rxByte   (rxByte),
      .ackSeen  (ackSeen),
      .sclIn    (sclIn),
      .sdaIn    (sdaIn),
      .sclOut   (sclOut),
      .sclOe    (sclOe),
      .sdaOut   (sdaOut),
      .sdaOe    (sdaOe)
   );

   // a failed load writes nothing, so defaults stay
   config_target_regs targets (
      .clk                 (clk),
      .rst_n               (rst_n),
      .byteWe              (byteWe),
      .byteAddr            (addr_reg),
      .byteData            (rxByte),
      .latGnt              (latGnt),
      .vendorId            (vendorId),
      .subsysId            (subsysId),
      .uidRom              (uidRom),
      .uidHigh             (uidHigh),
      .uidLow              (uidLow),
      .linkEnh             (linkEnh),
      .phyProgrammingAllow (phyProgrammingAllow),
      .miscBits            (miscBits),
      .phyCtrl             (phyCtrl)
   );

   // ************************************************
   // link enhancement use and read port
   // ************************************************
   assign priorityArbRespond = linkEnh[eeprom_loader_pkg::LE_UNFAIR_BIT];
   assign accelSupportNotify = linkEnh[eeprom_loader_pkg::LE_ACCEL_BIT];

   always_comb begin
      if (regOffset == eeprom_loader_pkg::LINK_ENH_OFFSET) begin
         regReadData = linkEnh & eeprom_loader_pkg::LINK_ENH_RMASK;
      end else begin
         regReadData = 32'h0000_0000;
      end
   end
endmodule // serial_eeprom_config_loader

// File: verification/loader_monitor.sv
// assertions on the loader top ports
// assumes one clock domain, bound to the loader top
`timescale 1ns/1ps
module loader_monitor (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        sclOut,
   input wire logic        sclOe,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic        loadRetry,
   input wire logic        loadFailed,
   input wire logic [7:0]  regOffset,
   input wire logic [31:0] regReadData,
   input wire logic [15:0] latGnt,
   input wire logic [15:0] vendorId,
   input wire logic [31:0] uidHigh,
   input wire logic [31:0] uidLow,
   input wire logic [7:0]  phyCtrl,
   input wire logic        priorityArbRespond,
   input wire logic        accelSupportNotify
);
   // ******
   // helper count
   // ******
   localparam int LOAD_MAX = 10000;
   localparam int STOP_MAX = 40;
   int busyCnt_reg;
   int busyCnt_next;
   always_comb busyCnt_next = loadRetry ? busyCnt_reg + 1 : 0;
   always_ff @(posedge clk) busyCnt_reg <= rst_n ? busyCnt_next : 0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence loadEnd;
      $fell(loadRetry) && !loadFailed;
   endsequence
   load_bounded_a: assert property (busyCnt_reg < LOAD_MAX)
      else $error("load runs too long");
   reset_retry_a: assert property ($rose(rst_n) |-> loadRetry)
      else $error("no retry after reset");
   drive_in_load_a: assert property (sdaOe || sclOe |-> loadRetry)
      else $error("bus driven outside load");
   open_drain_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
      else $error("pin driven high");
   fail_no_retry_a: assert property ($rose(loadFailed) |-> ##[1:STOP_MAX] !loadRetry)
      else $error("retry after failure");
   fail_defaults_a: assert property (loadFailed |-> latGnt == 16'h0
      && uidLow == 32'h0 && phyCtrl == 8'h0)
      else $error("targets loaded on failure");
   rsvd_zero_a: assert property (regOffset == 8'hF4 |->
      (regReadData & ~eeprom_loader_pkg::LINK_ENH_RMASK) == 32'h0) else $error("reserved set");
   enables_seen_a: assert property (regOffset == 8'hF4 |->
      regReadData[7] == priorityArbRespond && regReadData[1] == accelSupportNotify)
      else $error("enable readback differs");
   hold_after_a: assert property (loadEnd |->
      ##1 ($stable(uidHigh) && $stable(vendorId))[*4])
      else $error("field moved after load");
endmodule // loader_monitor
bind serial_eeprom_config_loader loader_monitor u_mon (.*);

// File: verification/eeprom_model.sv
// behavioural two-wire eeprom, sequential read
// assumes open-drain lines resolved by the bench with pull-ups
`timescale 1ns/1ps
module eeprom_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic ackEnable,
   output logic     sdaPull
);
   // ******
   // slave
   // ******
   logic [7:0] mem [32];
   logic [7:0] sh;
   logic [4:0] ptr;
   int         cnt;
   bit         act, rd, phase;
   initial sdaPull = 1'b0;
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1;
      cnt = 0;
      rd = 0;
      phase = 0;
   end
   always @(posedge sda) if (scl === 1'b1) act = 0;
   always @(posedge scl) if (act) begin
      if (cnt < 8 && !rd) sh = {sh[6:0], sda};
      if (cnt == 8 && rd && sda) act = 0; // master nack ends read
      cnt = (cnt == 8) ? 0 : cnt + 1;
   end
   // changes only while clock is low; released line floats to the pull-up
   always @(negedge scl) if (act) begin
      sdaPull = 1'b0;
      if (cnt == 8 && !rd) begin
         if (phase) begin
            ptr = sh[4:0];
            sdaPull = 1'b1;
         end else if (sh[7:1] == eeprom_loader_pkg::EEPROM_DEV_ADDR && ackEnable) begin
            rd = sh[0];
            phase = 1;
            sdaPull = 1'b1; // answers only to a master request
         end else act = 0;
      end else if (rd && cnt < 8) begin
         if (cnt == 0) begin
            sh = mem[ptr];
            ptr = ptr + 5'h1;
         end
         sdaPull = ~sh[7 - cnt];
      end
   end
endmodule // eeprom_model

// File: verification/testbench.sv
// bench: load from a programmed part, then from a silent part
// assumes the model answers at the package device address
`timescale 1ns/1ps
module testbench;
   // ******
   // setup
   // ******
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ackEn = 1'b1;
   logic [7:0]  regOffset = 8'h0;
   logic        sclOe, sdaOe, eePull, loadRetry, loadFailed, ppa, prio, accel;
   logic [1:0]  miscBits;
   logic [7:0]  uidRom, phyCtrl;
   logic [15:0] latGnt, vendorId, subsysId;
   logic [31:0] rdData, uidHigh, uidLow;
   int          failures = 0;
   int          n_checks = 0;
   wire         scl = ~sclOe;
   wire         sda = ~(sdaOe | eePull);
   // all bytes programmed; 11h bits 2-0 zero; 16h only bits 7 and 3
   logic [7:0]  img [23] = '{8'h5A, 8'h34, 8'h12, 8'h78, 8'h56, 8'hC2, 8'h9C, 8'h01, 8'h23,
      8'h45, 8'h67, 8'h89, 8'hAB, 8'hCD, 8'hEF, 8'h0, 8'hA0, 8'h10, 8'h80, 8'h0, 8'h0, 8'h0,
      8'h88};
   logic [39:0] rows [4] = '{{8'hF4, 32'hA082}, {8'hF0, 32'h0}, {8'h0, 32'h0}, {8'hFF, 32'h0}};
   always #2 clk = ~clk;
   serial_eeprom_config_loader u_dut (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda),
      .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe), .loadRetry(loadRetry),
      .loadFailed(loadFailed), .regOffset(regOffset), .regReadData(rdData), .latGnt(latGnt),
      .vendorId(vendorId), .subsysId(subsysId), .uidRom(uidRom), .uidHigh(uidHigh),
      .uidLow(uidLow), .phyProgrammingAllow(ppa), .miscBits(miscBits), .phyCtrl(phyCtrl),
      .priorityArbRespond(prio), .accelSupportNotify(accel));
   eeprom_model u_ee (.scl(scl), .sda(sda), .ackEnable(ackEn), .sdaPull(eePull));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic resetAndLoad;
      int i;
      @(posedge clk) #1 rst_n = 1'b0;
      repeat (12) @(posedge clk);
      #1 check(32'(loadRetry), 32'h1);
      check(32'({sclOe, sdaOe}), 32'h0);
      rst_n = 1'b1;
      repeat (50) @(posedge clk);
      #1 check(32'(loadRetry), 32'h1);
      for (i = 0; i < 20000 && loadRetry !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      check(32'(loadRetry), 32'h0);
   endtask
   // ******
   // tests
   // ******
   initial begin
      for (int k = 0; k < 23; k++) u_ee.mem[k] = img[k];
      resetAndLoad;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) #1 regOffset = rows[k][39:32];
         #1 check(rdData, rows[k][31:0]);
      end
      check(32'(latGnt), 32'h5A);
      check(32'({vendorId, subsysId}), 32'h1234_5678);
      check(32'(uidRom), 32'h9C);
      check(uidHigh, 32'h6745_2301);
      check(uidLow, 32'hEFCD_AB89);
      check(32'({prio, ppa, accel}), 32'h7);
      check(32'({miscBits, phyCtrl}), 32'h388);
      check(32'(loadFailed), 32'h0);
      $display("programmed part done");
      ackEn = 1'b0;
      resetAndLoad;
      check(32'(loadFailed), 32'h1);
      check(uidHigh | 32'(latGnt) | 32'(phyCtrl), 32'h0);
      $display("silent part done");
      test_done;
   end
   // one full load and one failed load take under half this span
   initial begin
      #100000;
      failures++;
      test_done;
   end
endmodule // testbench
